// [src/xbar_fabric.sv]
// Purpose: Five-master, five-target crossbar with per-target arbiters
// Assumes: Masters hold request fields until ack; one clock domain
// Notes:   Each target launch register is the bridge holding stage
`timescale 1ns/1ps
module xbar_fabric
  import xbar_pkg::*;
#(
  // Priority lists per target, slot 0 highest, 3 bits per master
  parameter logic [4:0][14:0] PRIO = {
    {M_HOST, M_CPU, M_DLO, M_DHI, M_FILL}, // DMA regs
    {M_HOST, M_CPU, M_DLO, M_DHI, M_FILL}, // serializer
    {M_FILL, M_HOST, M_CPU, M_DLO, M_DHI}, // periph
    {M_FILL, M_HOST, M_DLO, M_DHI, M_CPU}, // extmem
    {M_CPU, M_HOST, M_DLO, M_DHI, M_FILL}  // onchip
  }
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Master side
  xbar_if.device                bus,
  // Target side
  output logic [4:0]            t_req_o,
  output logic [4:0][31:0]      t_addr_o,
  output logic [4:0][31:0]      t_wdata_o,
  output logic [4:0]            t_we_o,
  output logic [4:0][3:0]       t_be_o,
  output logic [4:0][2:0]       t_master_o,
  input  wire logic [4:0]       t_ack_i,
  input  wire logic [4:0][31:0] t_rdata_i,
  // Status
  output logic                  onchip_bridge_reset_o
);

  typedef struct packed {
    logic [4:0][2:0]  owner;
    logic [4:0]       held;
    logic [4:0]       busy;
    logic [4:0]       treq;
    logic [4:0][31:0] taddr;
    logic [4:0][31:0] twdata;
    logic [4:0]       twe;
    logic [4:0][3:0]  tbe;
    logic [4:0]       ack;
    logic [4:0]       err;
    logic [4:0][31:0] rdata;
    logic             bridge_rst;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic [4:0][2:0] dtgt;
  logic [4:0] dok;

  // ------------------------------------------------------------
  // Per-master decode
  // ------------------------------------------------------------
  for (genvar m = 0; m < NM; m++) begin : g_dec
    dec_t d;
    logic [4:0] route;
    assign d = decode(bus.addr[m], bus.be[m]);
    assign route = (m == M_CPU)  ? ROUTE_CPU  :
                   (m == M_FILL) ? ROUTE_FILL :
                   (m == M_HOST) ? ROUTE_HOST : ROUTE_DMA;
    assign dtgt[m] = d.tgt;
    assign dok[m]  = (d.tgt != T_NONE) && d.size_ok && route[d.tgt];
  end

  // ------------------------------------------------------------
  // Arbitration and transfer
  // ------------------------------------------------------------
  always_comb begin
    logic       found;
    logic [2:0] m;
    logic [2:0] o;
    logic       idle;
    found = 1'b0;
    m = 3'h0;
    o = 3'h0;
    idle = 1'b0;
    next_st = st;
    bus.gnt = '0;
    next_st.ack = '0;
    next_st.err = '0;

    // Unroutable, unmapped or wrong-size accesses end with an error
    for (int i = 0; i < NM; i++) begin
      if (bus.req[i] && !st.ack[i] && !dok[i]) begin
        next_st.ack[i] = 1'b1;
        next_st.err[i] = 1'b1;
      end
    end

    for (int t = 0; t < NT; t++) begin
      o = st.owner[t];
      // Completion from the target side of the bridge stage
      if (st.treq[t] && t_ack_i[t]) begin
        next_st.treq[t] = 1'b0;
        next_st.busy[t] = 1'b0;
        next_st.ack[o] = 1'b1;
        next_st.rdata[o] = t_rdata_i[t];
      end
      // Ownership kept while a burst is locked on
      idle = !st.busy[t] || (st.treq[t] && t_ack_i[t]);
      if (!st.busy[t] && !bus.lock[o]) begin
        next_st.held[t] = 1'b0;
      end
      found = 1'b0;
      if (!st.busy[t]) begin
        for (int p = 0; p < NM; p++) begin
          m = PRIO[t][p*3 +: 3];
          if (!found && bus.req[m] && !st.ack[m] && dok[m] &&
              dtgt[m] == 3'(t) &&
              !(st.held[t] && bus.lock[o] && o != m) &&
              !(3'(t) == T_ONCHIP && st.bridge_rst &&
                m >= M_DHI)) begin
            found = 1'b1;
            bus.gnt[m] = 1'b1;
            next_st.owner[t] = m;
            next_st.held[t] = 1'b1;
            if (3'(t) == T_PERIPH && bus.addr[m] == BRIDGE_CTRL_ADDR) begin
              // Local register, answered without a target cycle
              next_st.ack[m] = 1'b1;
              next_st.rdata[m] = {31'h0, st.bridge_rst};
              if (bus.we[m]) begin
                next_st.bridge_rst = bus.wdata[m][BRIDGE_RST_BIT];
              end
            end else begin
              // Bridge stage captures the beat and replays it
              next_st.busy[t] = 1'b1;
              next_st.treq[t] = 1'b1;
              next_st.taddr[t] = bus.addr[m];
              next_st.twdata[t] = bus.wdata[m];
              next_st.twe[t] = bus.we[m];
              next_st.tbe[t] = bus.be[m];
            end
          end
        end
      end
      if (idle && !found && st.busy[t]) begin
        next_st.busy[t] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.bridge_rst <= BRIDGE_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.ack = st.ack;
  assign bus.err = st.err;
  assign bus.rdata = st.rdata;
  assign t_req_o = st.treq;
  assign t_addr_o = st.taddr;
  assign t_wdata_o = st.twdata;
  assign t_we_o = st.twe;
  assign t_be_o = st.tbe;
  assign t_master_o = st.owner;
  assign onchip_bridge_reset_o = st.bridge_rst;

endmodule

// [src/xbar_pkg.sv]
// Purpose: Constants, address map and decode shared by both crossbar ends
// Assumes: One clock; all three system rates run from clk_i
// Notes:   Master and target numbering is used by both ends
package xbar_pkg;

  localparam int NM = 5;
  localparam int NT = 5;

  // --------------------------------------------------------------
  // Master and target numbers
  // --------------------------------------------------------------
  localparam logic [2:0] M_CPU  = 3'h0;
  localparam logic [2:0] M_FILL = 3'h1;
  localparam logic [2:0] M_DHI  = 3'h2;
  localparam logic [2:0] M_DLO  = 3'h3;
  localparam logic [2:0] M_HOST = 3'h4;

  localparam logic [2:0] T_ONCHIP = 3'h0;
  localparam logic [2:0] T_EXTMEM = 3'h1;
  localparam logic [2:0] T_PERIPH = 3'h2;
  localparam logic [2:0] T_SERIAL = 3'h3;
  localparam logic [2:0] T_DMAREG = 3'h4;
  localparam logic [2:0] T_NONE   = 3'h7;

  // Reachability [master][target], one row per master, M_DHI and M_DLO sharing ROUTE_DMA
  localparam logic [4:0] ROUTE_CPU  = 5'h16;
  localparam logic [4:0] ROUTE_FILL = 5'h03;
  localparam logic [4:0] ROUTE_DMA  = 5'h1f;
  localparam logic [4:0] ROUTE_HOST = 5'h1f;

  // --------------------------------------------------------------
  // Bridge control register
  // --------------------------------------------------------------
  localparam logic [31:0] BRIDGE_CTRL_ADDR  = 32'h4000_0024;
  localparam logic        BRIDGE_CTRL_RESET = 1'h1;
  localparam int          BRIDGE_RST_BIT    = 0;

  // --------------------------------------------------------------
  // Address map
  // --------------------------------------------------------------
  localparam logic [31:0] ONCHIP_LO  = 32'h1000_0000;
  localparam logic [31:0] ONCHIP_HI  = 32'h1003_ffff;
  localparam logic [31:0] PERIPH_LO  = 32'h4000_0000;
  localparam logic [31:0] PERIPH_HI  = 32'h4a00_007f;
  localparam logic [7:0]  SERIAL_LO  = 8'h54;
  localparam logic [7:0]  SERIAL_HI  = 8'h56;
  localparam logic [31:0] DMACTL_LO  = 32'h6000_0000;
  localparam logic [31:0] DMACTL_HI  = 32'h6000_008f;
  localparam logic [23:0] EVT_LO     = 24'h00_8000;
  localparam logic [23:0] EVT_HI     = 24'h00_807f;
  localparam logic [23:0] XFR_LO     = 24'h00_80a0;
  localparam logic [23:0] XFR_HI     = 24'h00_81ff;
  localparam logic [7:0]  TBL0_TOP   = 8'h61;
  localparam logic [7:0]  TBL1_TOP   = 8'h62;
  localparam logic [31:0] EXTMEM_LO  = 32'h8000_0000;
  localparam logic [31:0] EXTMEM_HI  = 32'h9fff_ffff;
  localparam logic [31:0] EXTREG_LO  = 32'hf000_0000;
  localparam logic [31:0] EXTREG_HI  = 32'hf000_00bf;
  localparam logic [31:0] DRAM_CFG   = 32'hf000_0000;
  localparam logic [3:0]  BE_WORD    = 4'hf;
  localparam logic [3:0]  BE_TOPBYTE = 4'h8;

  // --------------------------------------------------------------
  // Agent register offsets (classic Wishbone)
  // --------------------------------------------------------------
  localparam logic [7:0] AG_ADDR   = 8'h00;
  localparam logic [7:0] AG_WDATA  = 8'h04;
  localparam logic [7:0] AG_CTRL   = 8'h08;
  localparam logic [7:0] AG_STATUS = 8'h0c;
  localparam logic [7:0] AG_RDATA  = 8'h10;
  localparam int CTL_GO   = 0;
  localparam int CTL_WE   = 1;
  localparam int CTL_LOCK = 2;
  localparam int CTL_BE   = 4;
  localparam int CTL_PORT = 8;
  localparam int ST_BUSY  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_REFUSED = 2;

  typedef struct packed {
    logic [2:0] tgt;
    logic       size_ok;
  } dec_t;

  // Address to target with access-size check
  function automatic dec_t decode(input logic [31:0] a,
                                  input logic [3:0]  be);
    dec_t d;
    logic word;
    d = '{tgt: T_NONE, size_ok: 1'b1};
    word = (be == BE_WORD);
    if (a >= ONCHIP_LO && a <= ONCHIP_HI) begin
      d.tgt = T_ONCHIP;
    end else if (a >= PERIPH_LO && a <= PERIPH_HI) begin
      d.tgt = T_PERIPH;
      d.size_ok = word;
    end else if (a[31:24] >= SERIAL_LO && a[31:24] <= SERIAL_HI) begin
      d.tgt = T_SERIAL;
      d.size_ok = word;
    end else if (a >= DMACTL_LO && a <= DMACTL_HI) begin
      d.tgt = T_DMAREG;
      d.size_ok = word;
    end else if ((a[31:24] == TBL0_TOP || a[31:24] == TBL1_TOP) &&
                 ((a[23:0] >= EVT_LO && a[23:0] <= EVT_HI) ||
                  (a[23:0] >= XFR_LO && a[23:0] <= XFR_HI))) begin
      d.tgt = T_DMAREG;
    end else if (a >= EXTMEM_LO && a <= EXTMEM_HI) begin
      d.tgt = T_EXTMEM;
    end else if (a >= EXTREG_LO && a <= EXTREG_HI) begin
      d.tgt = T_EXTMEM;
      d.size_ok = word || (a == DRAM_CFG && be == BE_TOPBYTE);
    end
    return d;
  endfunction

endpackage

// [src/xbar_if.sv]
// Purpose: Master-side link between the bus masters and the crossbar
// Assumes: Both ends clocked by the same clk_i
// Notes:   Index of each vector is the master number
`timescale 1ns/1ps
interface xbar_if;
  logic [4:0]       req;
  logic [4:0]       lock;
  logic [4:0]       we;
  logic [4:0][31:0] addr;
  logic [4:0][31:0] wdata;
  logic [4:0][3:0]  be;
  logic [4:0]       gnt;
  logic [4:0]       ack;
  logic [4:0]       err;
  logic [4:0][31:0] rdata;

  modport device (
    input  req, lock, we, addr, wdata, be,
    output gnt, ack, err, rdata
  );
  modport master (
    output req, lock, we, addr, wdata, be,
    input  gnt, ack, err, rdata
  );
endinterface

// [src/xbar_master_agent.sv]
// Purpose: Software-driven bus master standing in for all five masters
// Assumes: Classic Wishbone slave, one access outstanding at a time
// Notes:   Reserved bridge control bits are forced to zero on write
`timescale 1ns/1ps
module xbar_master_agent
  import xbar_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Crossbar side
  xbar_if.master           bus
);

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic        lock;
    logic [3:0]  be;
    logic [2:0]  port;
    logic        busy;
    logic        err;
    logic        refused;
    logic [31:0] rdata;
    logic [4:0]  req;
    logic        ack;
    logic [31:0] dat;
  } state_t;

  state_t st;
  state_t next_st;

  always_comb begin
    logic  hit;
    dec_t  d;
    hit = wb_cyc_i && wb_stb_i && !st.ack;
    d = decode(st.addr, st.be);
    next_st = st;
    next_st.ack = hit;
    next_st.dat = 32'h0;

    // Access completes on the port's ack; the request then drops
    if (st.busy && bus.ack[st.port]) begin
      next_st.busy = 1'b0;
      next_st.req = '0;
      next_st.rdata = bus.rdata[st.port];
      next_st.err = bus.err[st.port];
    end

    if (hit && !wb_we_i) begin
      unique case (wb_adr_i[7:0])
        AG_ADDR:   next_st.dat = st.addr;
        AG_WDATA:  next_st.dat = st.wdata;
        AG_CTRL:   next_st.dat = {20'h0, 1'b0, st.port, st.be,
                                  1'b0, st.lock, st.we, 1'b0};
        AG_STATUS: next_st.dat = {29'h0, st.refused, st.err, st.busy};
        AG_RDATA:  next_st.dat = st.rdata;
        default:   next_st.dat = 32'h0;
      endcase
    end

    // Writes take effect at the edge that carries ack
    if (wb_cyc_i && wb_stb_i && st.ack && wb_we_i && !st.busy &&
        wb_sel_i == 4'hf) begin
      unique case (wb_adr_i[7:0])
        AG_ADDR:  next_st.addr = wb_dat_i;
        AG_WDATA: next_st.wdata = wb_dat_i;
        AG_CTRL: begin
          next_st.we = wb_dat_i[CTL_WE];
          next_st.lock = wb_dat_i[CTL_LOCK];
          next_st.be = wb_dat_i[CTL_BE +: 4];
          next_st.port = wb_dat_i[CTL_PORT +: 3];
          if (wb_dat_i[CTL_GO]) begin
            if (d.tgt == T_NONE ||
                wb_dat_i[CTL_PORT +: 3] > M_HOST) begin
              next_st.refused = 1'b1;
            end else begin
              next_st.refused = 1'b0;
              next_st.err = 1'b0;
              next_st.busy = 1'b1;
              next_st.req[wb_dat_i[CTL_PORT +: 3]] = 1'b1;
              if (st.addr == BRIDGE_CTRL_ADDR) begin
                next_st.wdata = st.wdata & 32'h1;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs; fields held steady until ack, as the stall needs
  // ------------------------------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign bus.req = st.req;
  assign bus.lock = st.lock ? (5'h1 << st.port) : 5'h0;
  assign bus.we = {NM{st.we}};
  assign bus.addr = {NM{st.addr}};
  assign bus.wdata = {NM{st.wdata}};
  assign bus.be = {NM{st.be}};

endmodule

// [sim/xbar_link_properties.sv]
// Purpose: Assertions on the master link between agent and crossbar
// Assumes: One clock domain; link signals taken from xbar_if
// Notes:   Decode uses the shared address map of the package
`timescale 1ns/1ps
module xbar_link_checker
  import xbar_pkg::*;
(
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // Link
  input wire logic [4:0]       req,
  input wire logic [4:0]       lock,
  input wire logic [4:0][31:0] addr,
  input wire logic [4:0][3:0]  be,
  input wire logic [4:0]       gnt,
  input wire logic [4:0]       ack,
  input wire logic [4:0]       err
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----
  // Per-master checks
  // ----
  for (genvar m = 0; m < 5; m++) begin : g_m
    dec_t d;
    assign d = decode(addr[m], be[m]);
    a_gnt_open_req: assert property (gnt[m] |-> req[m] && !ack[m])
      else $error("grant without open request");
    a_err_with_ack: assert property (err[m] |-> ack[m])
      else $error("error flag without ack");
    a_ack_pulse: assert property (ack[m] |=> !ack[m])
      else $error("ack longer than one cycle");
    a_unmapped_err: assert property (
      $rose(req[m]) && d.tgt == T_NONE |=> ack[m] && err[m])
      else $error("unmapped access not refused");
    a_size_err: assert property (
      $rose(req[m]) && !d.size_ok |=> ack[m] && err[m])
      else $error("wrong size access not refused");
    a_done_bound: assert property (gnt[m] |-> ##[1:40] ack[m])
      else $error("granted access never completed");
    a_single_gnt: assert property (gnt[m] |=> (!gnt[m]) [*2])
      else $error("access granted twice");
    a_stall_holds: assert property (
      req[m] && !ack[m] |=> req[m] && $stable(addr[m]))
      else $error("stalled request dropped or moved");
    a_ack_after_req: assert property (ack[m] |-> $past(req[m]))
      else $error("ack without request");
  end

  c_refused: cover property (|(ack & err));
  c_done: cover property (|(ack & ~err));
  c_locked: cover property (|(gnt & lock));
endmodule

// [sim/crossbar_switch_fabric_test.sv]
// Purpose: Self-checking bench for agent and crossbar joined by xbar_if
// Assumes: Bench answers every target one cycle after its request
// Notes:   Only one master active at a time, so contention is unseen
`timescale 1ns/1ps
module crossbar_switch_fabric_test;
  import xbar_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [3:0]  be;
    logic [2:0]  p;
    logic        w;
    logic        l;
    logic        e;
    logic [2:0]  t;
  } case_t;
  logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0]      wb_adr_i, wb_dat_i, wb_dat_o, cap_a, cap_d;
  logic [3:0]       wb_sel_i;
  logic [4:0]       t_req_o, t_we_o, t_ack_i;
  logic [4:0][31:0] t_addr_o, t_wdata_o, t_rdata_i;
  logic [4:0][3:0]  t_be_o;
  logic [4:0][2:0]  t_master_o;
  logic [2:0]       cap_m;
  logic             cap_w, onchip_bridge_reset_o;
  int               errors, checked;

  xbar_if bus ();
  xbar_fabric i_xbar_fabric (.clk_i, .rst_i, .bus(bus), .t_req_o,
    .t_addr_o, .t_wdata_o, .t_we_o, .t_be_o, .t_master_o, .t_ack_i,
    .t_rdata_i, .onchip_bridge_reset_o);
  xbar_master_agent i_xbar_master_agent (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .bus(bus));
  xbar_link_checker i_xbar_link_checker (.clk_i(clk_i), .rst_i(rst_i),
    .req(bus.req), .lock(bus.lock), .addr(bus.addr), .be(bus.be),
    .gnt(bus.gnt), .ack(bus.ack), .err(bus.err));

  // ----
  // Targets: answer one cycle after request, record what arrived
  // ----
  always_comb begin
    for (int t = 0; t < 5; t++) begin
      t_rdata_i[t] = {29'h1a00_0000, 3'(t)};
    end
  end
  always @(posedge clk_i) begin
    t_ack_i <= rst_i ? 5'h00 : (t_req_o & ~t_ack_i);
    for (int t = 0; t < 5; t++) begin
      if (t_req_o[t] && !t_ack_i[t]) begin
        cap_a <= t_addr_o[t];
        cap_d <= t_wdata_o[t];
        cap_w <= t_we_o[t];
        cap_m <= t_master_o[t];
      end
    end
  end

  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    // Ack is looked at mid-cycle, then acted on at the next rising edge
    @(negedge clk_i);
    while (wb_ack_o !== 1'b1) @(negedge clk_i);
    q = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic acc(input case_t c, input logic [31:0] d,
                     output logic [31:0] st, output logic [31:0] q);
    wb(1'b1, AG_ADDR, c.a, q);
    wb(1'b1, AG_WDATA, d, q);
    wb(1'b1, AG_CTRL, {21'h0, c.p, c.be, 1'b0, c.l, c.w, 1'b1}, q);
    do wb(1'b0, AG_STATUS, 32'h0, st); while (st[ST_BUSY] !== 1'b0);
    wb(1'b0, AG_RDATA, 32'h0, q);
  endtask

  // Address, lanes, port, write, lock, refused, target
  case_t tbl [18] = '{
    '{32'h1000_0000, 4'hf, 3'h2, 1'b0, 1'b0, 1'b0, 3'h0},
    '{32'h1003_fffc, 4'h1, 3'h4, 1'b1, 1'b0, 1'b0, 3'h0},
    '{32'h1004_0000, 4'hf, 3'h4, 1'b0, 1'b0, 1'b1, 3'h0},
    '{32'h4000_0000, 4'hf, 3'h3, 1'b0, 1'b0, 1'b0, 3'h2},
    '{32'h4a00_007c, 4'hf, 3'h0, 1'b1, 1'b0, 1'b0, 3'h2},
    '{32'h4a00_0080, 4'hf, 3'h3, 1'b0, 1'b0, 1'b1, 3'h0},
    '{32'h4000_0010, 4'h1, 3'h2, 1'b1, 1'b0, 1'b1, 3'h0},
    '{32'h54ff_fffc, 4'hf, 3'h2, 1'b1, 1'b1, 1'b0, 3'h3},
    '{32'h5600_0000, 4'hf, 3'h2, 1'b1, 1'b0, 1'b0, 3'h3},
    '{32'h6100_8000, 4'h1, 3'h3, 1'b0, 1'b0, 1'b0, 3'h4},
    '{32'h6100_8080, 4'hf, 3'h3, 1'b0, 1'b0, 1'b1, 3'h0},
    '{32'h6000_0000, 4'hf, 3'h0, 1'b0, 1'b0, 1'b0, 3'h4},
    '{32'h8000_0000, 4'h2, 3'h1, 1'b0, 1'b0, 1'b0, 3'h1},
    '{32'h9fff_fffc, 4'hf, 3'h0, 1'b1, 1'b0, 1'b0, 3'h1},
    '{32'hf000_0000, 4'h8, 3'h4, 1'b1, 1'b0, 1'b0, 3'h1},
    '{32'hf000_0004, 4'h8, 3'h4, 1'b1, 1'b0, 1'b1, 3'h0},
    '{32'h4000_0000, 4'hf, 3'h1, 1'b0, 1'b0, 1'b1, 3'h0},
    '{32'h1000_0000, 4'hf, 3'h1, 1'b0, 1'b0, 1'b0, 3'h0}
  };

  // ----
  // Clock, watchdog, main sequence
  // ----
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done();
  end

  initial begin : main
    case_t br;
    logic [31:0] st, q;
    br = '{BRIDGE_CTRL_ADDR, 4'hf, 3'h0, 1'b0, 1'b0, 1'b0, 3'h2};
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    errors = 0;
    checked = 0;
    do_reset();
    acc(br, 32'h0, st, q);
    check(q, 32'h1);
    check({31'h0, onchip_bridge_reset_o}, 32'h1);
    br.w = 1'b1;
    acc(br, 32'hffff_fffe, st, q);
    br.w = 1'b0;
    acc(br, 32'h0, st, q);
    check(q, 32'h0);
    check({31'h0, onchip_bridge_reset_o}, 32'h0);
    $display("bridge control test done");
    for (int i = 0; i < 18; i++) begin
      acc(tbl[i], ~tbl[i].a, st, q);
      // Unmapped starts are refused by the agent, others end in error
      check({31'h0, st[ST_ERR] | st[ST_REFUSED]}, {31'h0, tbl[i].e});
      if (!tbl[i].e) begin
        check(cap_a, tbl[i].a);
        check({29'h0, cap_m}, {29'h0, tbl[i].p});
        check({31'h0, cap_w}, {31'h0, tbl[i].w});
        if (tbl[i].w)
          check(cap_d, ~tbl[i].a);
        else
          check(q, {29'h1a00_0000, tbl[i].t});
      end
    end
    $display("decode test done");
    do_reset();
    acc(br, 32'h0, st, q);
    check(q, 32'h1);
    check({31'h0, onchip_bridge_reset_o}, 32'h1);
    $display("second reset test done");
    test_done();
  end
endmodule
